/* File: rtl/serial_cmd_interp.sv */
// serial terminal command interpreter with parameter store and front panel
`timescale 1ns/1ps
`default_nettype none

module serial_cmd_interp
	import cmd_interp_pkg::*;
#(
	parameter int BIT_CYCLES = BIT_CYCLES_DFLT
) (
	input  wire logic        CORE_CLK_I,      // 40 MHz system clock
	input  wire logic        RESET_I,         // async reset, active high
	input  wire logic        RX_I,            // serial data from terminal
	output var  logic        TX_O,            // serial data to terminal
	input  wire logic [11:0] HDR_TEMP_I,      // header temperature, F
	input  wire logic [11:0] OAT_TEMP_I,      // outside air temperature, F
	input  wire logic [11:0] INDOOR_TEMP_I,   // indoor air temperature, F
	input  wire logic [11:0] FIRE_RATE_I,     // firing rate, percent
	input  wire logic [11:0] HDR_TARGET_I,    // computed header target, F
	input  wire logic        FIELD_ADJUST_KEY_KEY_I, // field adjust key press
	input  wire logic        SELECT_KEY_I,    // setting select key press
	input  wire logic        UP_KEY_I,        // up arrow key press
	input  wire logic        DOWN_KEY_I,      // down arrow key press
	output var  logic        FIELD_ADJUST_KEY_LAMP_O,// field adjust indicator
	output var  logic [4:0]  SETTING_SEL_O,   // setting on top line
	output var  logic [11:0] SETTING_VAL_O,   // value on second line
	output var  logic        SERIAL_PORT_MODE_O, // 0 terminal, 1 network
	output var  logic        SESSION_OPEN_O,  // login accepted
	input  wire logic [4:0]  REG_ADDR_I,      // register index
	input  wire logic [15:0] REG_WDATA_I,     // register write data
	input  wire logic        REG_WR_I,        // register write strobe
	input  wire logic        REG_RD_I,        // register read strobe
	output var  logic [15:0] REG_RDATA_O      // read data, cycle after
);

	localparam logic [CNT_W-1:0] BIT_LAST  = CNT_W'(BIT_CYCLES - 1);
	localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(BIT_CYCLES / 2 - 1);

	state_s s;
	state_s n;

	logic signed [14:0] s_wv;
	logic               wv_ok;
	assign s_wv  = s.neg ? -$signed({1'b0, s.prev}) :
		$signed({1'b0, s.prev});
	assign wv_ok = s_wv >= $signed(PAR_MIN[s.num[4:0]]) &&
		s_wv <= $signed(PAR_MAX[s.num[4:0]]);

	////////////////////////////////////////////////////////////////////////

	// parameter value as seen by the terminal, panel and register port
	function automatic logic signed [11:0] pval(input logic [6:0] idx);
		logic signed [11:0] o;
		o = $signed(OAT_TEMP_I);
		case (idx)
			7'h00: pval = $signed(HDR_TEMP_I);
			7'h01: pval = (o < OAT_MIN) ? OAT_MIN :
				(o > OAT_MAX) ? OAT_MAX : o;
			7'h02: pval = $signed(INDOOR_TEMP_I);
			7'h03: pval = $signed(FIRE_RATE_I);
			7'h04: pval = $signed(HDR_TARGET_I);
			default: pval = $signed(s.params[idx[4:0]]);
		endcase
	endfunction : pval

	////////////////////////////////////////////////////////////////////////

	always_comb begin
		logic [7:0]         c;
		logic [3:0]         d;
		logic               isdig;
		logic signed [11:0] v;
		logic [9:0]         m;
		logic [2:0]         k;
		logic [0:4][7:0]    b;
		c     = s.rx_byte;
		d     = 4'(c - CHR_ZERO);
		isdig = (c >= CHR_ZERO) && (c <= CHR_NINE);
		v     = pval(s.num);
		m     = '0;
		k     = '0;
		b     = '0;
		n     = s;
		n.rx_vld = 1'b0;

		// receiver: start, 8 data, stop, no parity
		if (!s.rx_busy) begin
			if (!RX_I) begin
				n.rx_busy = 1'b1;
				n.rx_cnt  = HALF_LAST;
				n.rx_bit  = 4'h0;
			end
		end else if (s.rx_cnt != '0) begin
			n.rx_cnt = s.rx_cnt - 1'b1;
		end else begin
			n.rx_cnt = BIT_LAST;
			n.rx_bit = s.rx_bit + 1'b1;
			if (s.rx_bit == 4'h0) begin
				n.rx_busy = !RX_I;
			end else if (s.rx_bit < STOP_BIT_IDX) begin
				n.rx_sh = {RX_I, s.rx_sh[7:1]};
			end else begin
				// a low stop bit is a framing error: the byte is dropped
				n.rx_busy = 1'b0;
				n.rx_vld  = RX_I;
				n.rx_byte = s.rx_sh;
			end
		end

		// reply text for a view request, leading zeros suppressed
		m = (v < 0) ? 10'(-v) : 10'(v);
		if (m > MAG_LIMIT)
			m = MAG_LIMIT;
		if (v < 0) begin
			b[k] = CHR_MINUS;
			k = k + 1'b1;
		end
		if (m >= 10'd100) begin
			b[k] = CHR_ZERO + 8'(m / 10'd100);
			k = k + 1'b1;
		end
		if (m >= 10'd10) begin
			b[k] = CHR_ZERO + 8'((m / 10'd10) % 10'd10);
			k = k + 1'b1;
		end
		b[k] = CHR_ZERO + 8'(m % 10'd10);
		k = k + 1'b1;
		b[k] = CHR_CR;
		k = k + 1'b1;

		if (s.rx_vld) begin
			// flow control characters only pause or resume the transmitter
			if (c == CHR_XOFF) begin
				n.xoff = 1'b1;
			end else if (c == CHR_XON) begin
				n.xoff = 1'b0;
			end else if (s.port_mode == PORT_MODE_NORMAL &&
					s.st != ST_SEND) begin
				case (s.st)
					ST_LOGIN: begin
						if (c == CHR_CR) begin
							n.lidx = 3'h0;
							if (s.lidx == LOGIN_LEN) begin
								n.logged = 1'b1;
								n.st     = ST_CMD;
							end
						end else if (s.lidx < LOGIN_LEN &&
								c == LOGIN_STR[s.lidx]) begin
							n.lidx = s.lidx + 1'b1;
						end else begin
							n.lidx = 3'h0;
							n.st   = ST_SKIP;
						end
					end
					ST_CMD: begin
						n.num  = 7'h00;
						n.ndig = 2'h0;
						if (c == CHR_QUERY || c == CHR_SET) begin
							n.cmd_write = (c == CHR_SET);
							n.st        = ST_NUM;
						end else if (c != CHR_CR) begin
							n.st = ST_SKIP;
						end
					end
					ST_NUM: begin
						if (isdig && s.ndig != 2'h2) begin
							n.num  = 7'(s.num * 7'd10 + 7'(d));
							n.ndig = s.ndig + 1'b1;
						end else if (c == CHR_CR && !s.cmd_write &&
								s.ndig == 2'h2 && s.num <= LAST_PAR) begin
							n.rsp  = b;
							n.rlen = k;
							n.ridx = 3'h0;
							n.st   = ST_SEND;
						end else if (c == CHR_EQ && s.cmd_write &&
								s.ndig == 2'h2) begin
							n.acc  = '0;
							n.prev = '0;
							n.neg  = 1'b0;
							n.vdig = 3'h0;
							n.st   = ST_VAL;
						end else begin
							n.st = (c == CHR_CR) ? ST_CMD : ST_SKIP;
						end
					end
					ST_VAL: begin
						if (c == CHR_MINUS && s.vdig == 3'h0 && !s.neg) begin
							n.neg = 1'b1;
						// last digit is the dropped trailing zero
						end else if (isdig && s.vdig < MAX_VAL_DIGITS) begin
							n.prev = s.acc;
							n.acc  = 14'(s.acc * 14'd10 + 14'(d));
							n.vdig = s.vdig + 1'b1;
						end else if (c == CHR_CR) begin
							n.st = ST_CMD;
							if (s.vdig >= 3'h2 && s.num >= FIRST_RW_PAR &&
									s.num <= LAST_PAR && wv_ok)
								n.params[s.num[4:0]] = 12'(s_wv);
						end else begin
							n.st = ST_SKIP;
						end
					end
					ST_SKIP: begin
						if (c == CHR_CR)
							n.st = s.logged ? ST_CMD : ST_LOGIN;
					end
					default: n.st = ST_LOGIN;
				endcase
			end
		end

		// transmitter; new characters held while paused
		if (s.tx_busy) begin
			if (s.tx_cnt != '0) begin
				n.tx_cnt = s.tx_cnt - 1'b1;
			end else if (s.tx_bit == FRAME_LAST_BIT) begin
				n.tx_busy = 1'b0;
			end else begin
				n.tx_cnt  = BIT_LAST;
				n.tx_bit  = s.tx_bit + 1'b1;
				n.tx_line = s.tx_sh[0];
				n.tx_sh   = {1'b1, s.tx_sh[8:1]};
			end
		end else if (s.st == ST_SEND && !s.xoff) begin
			n.tx_busy = 1'b1;
			n.tx_cnt  = BIT_LAST;
			n.tx_bit  = 4'h0;
			n.tx_line = 1'b0;
			n.tx_sh   = {1'b1, s.rsp[s.ridx]};
			n.ridx    = s.ridx + 1'b1;
			if (s.ridx + 1'b1 == s.rlen)
				n.st = ST_CMD;
		end

		if (FIELD_ADJUST_KEY_KEY_I) begin
			n.fadj = !s.fadj;
		end else if (s.fadj) begin
			// select steps, arrows adjust within range
			if (SELECT_KEY_I) begin
				n.sel = (s.sel == SEL_PORT_MODE) ? SEL_FIRST : s.sel + 1'b1;
			end else if (s.sel == SEL_PORT_MODE) begin
				if (UP_KEY_I)
					n.port_mode = PORT_MODE_NET;
				else if (DOWN_KEY_I)
					n.port_mode = PORT_MODE_NORMAL;
			end else if (UP_KEY_I &&
					$signed(s.params[s.sel]) < $signed(PAR_MAX[s.sel])) begin
				n.params[s.sel] = s.params[s.sel] + 1'b1;
			end else if (DOWN_KEY_I &&
					$signed(s.params[s.sel]) > $signed(PAR_MIN[s.sel])) begin
				n.params[s.sel] = s.params[s.sel] - 1'b1;
			end
		end
		n.disp = (s.sel == SEL_PORT_MODE) ? {11'h000, s.port_mode} :
			s.params[s.sel <= SEL_LAST_PAR ? s.sel : SEL_FIRST];

		// register port: only the port mode is writable here
		n.rdata = '0;
		if (REG_WR_I && REG_ADDR_I == ADDR_PORT_MODE)
			n.port_mode = REG_WDATA_I[0];
		if (REG_RD_I) begin
			if (REG_ADDR_I == ADDR_PORT_MODE)
				n.rdata = {15'h0000, s.port_mode};
			else if (REG_ADDR_I <= SEL_LAST_PAR)
				n.rdata = 16'(pval({2'h0, REG_ADDR_I}));
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			s           <= '0;
			s.st        <= ST_LOGIN;
			s.tx_line   <= 1'b1;
			s.params    <= PAR_RST;
			s.port_mode <= PORT_MODE_RST;
			s.sel       <= SEL_FIRST;
		end else begin
			s <= n;
		end
	end

	// readings pass through in degrees F unchanged, except outside air, which is clamped to -60..80
	assign TX_O               = s.tx_line;
	assign FIELD_ADJUST_KEY_LAMP_O   = s.fadj;
	assign SETTING_SEL_O      = s.sel;
	assign SETTING_VAL_O      = s.disp;
	assign SERIAL_PORT_MODE_O = s.port_mode;
	assign SESSION_OPEN_O     = s.logged;
	assign REG_RDATA_O        = s.rdata;

	////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RESET_I);

	sequence cr_seen;
		s.rx_vld && s.rx_byte == CHR_CR;
	endsequence

	sequence active_char;
		s.rx_vld && s.rx_byte != CHR_XON && s.rx_byte != CHR_XOFF &&
			s.port_mode == PORT_MODE_NORMAL;
	endsequence

	a_fadj_lamp_toggle: assert property (
		FIELD_ADJUST_KEY_KEY_I |=> FIELD_ADJUST_KEY_LAMP_O != $past(FIELD_ADJUST_KEY_LAMP_O))
		else $error("field adjust lamp did not toggle");
	a_net_mode_frozen: assert property (
		s.port_mode == PORT_MODE_NET && !s.fadj && !REG_WR_I
			|=> $stable(s.params) && $stable(s.logged))
		else $error("serial command acted on in network mode");
	a_no_session_reply: assert property (
		!s.logged |-> s.st != ST_SEND)
		else $error("reply sent before login");
	a_view_reply_start: assert property (
		(cr_seen ##0 active_char ##0 s.st == ST_NUM && !s.cmd_write &&
			s.ndig == 2'h2 && s.num <= LAST_PAR)
			|=> s.st == ST_SEND ##1 s.tx_busy || s.xoff)
		else $error("view request not answered");
	a_write_stores: assert property (
		(cr_seen ##0 active_char ##0 s.st == ST_VAL && !s.fadj &&
			s.vdig >= 3'h2 && s.num >= FIRST_RW_PAR && s.num <= LAST_PAR &&
			wv_ok) |=> s.params[$past(s.num[4:0])] == $past(12'(s_wv)))
		else $error("write value not stored without trailing digit");
	a_view_only_kept: assert property (
		(cr_seen ##0 s.st == ST_VAL && s.num < FIRST_RW_PAR && !s.fadj)
			|=> $stable(s.params))
		else $error("view-only parameter changed");
	a_par05_range: assert property (
		$signed(s.params[5]) >= 12'sd32 && $signed(s.params[5]) <= 12'sd120)
		else $error("parameter 05 out of range");
	a_par17_range: assert property (
		s.params[17] <= 12'h002)
		else $error("parameter 17 out of range");
	a_par12_range: assert property (
		s.params[12] >= 12'h028 && s.params[12] <= 12'h0dc)
		else $error("parameter 12 out of range");
	a_par20_range: assert property (
		s.params[20] <= 12'h063)
		else $error("parameter 20 out of range");
	a_xoff_holds_tx: assert property (
		s.xoff |=> !$rose(s.tx_busy))
		else $error("character started while paused");
	a_tx_bit_edge: assert property (
		$changed(TX_O) |-> $past(s.tx_cnt) == '0)
		else $error("serial line changed mid bit");
	a_reply_ends_cr: assert property (
		s.st == ST_SEND |-> s.rsp[s.rlen - 1'b1] == CHR_CR)
		else $error("reply not terminated by CR");
	a_oor_ignored: assert property (
		(cr_seen ##0 s.st == ST_VAL && !wv_ok && !s.fadj) |=> $stable(s.params))
		else $error("out of range write stored");

endmodule : serial_cmd_interp

`default_nettype wire

/* File: rtl/cmd_interp_pkg.sv */
// constants, types and state record of the serial parameter command block
//
// Function
// - serial link runs at 9600 baud
// - eight data bits, no parity, one stop
// - works with XON/XOFF or no flow control
// - commands accepted only in plain terminal mode
// - exact login string plus CR opens session
// - ?NN CR replies current parameter value
// - @NN=value plus trailing zero stores value
// - parameters 00 to 04 are view only
// - temperatures reported in degrees Fahrenheit
// - parameter 05 range 32..120, default 70
// - parameter 17 selects target mode, default 1
// - parameter 07 range 40..220, default 160
// - parameter 12 range 40..220, default 220
// - parameter 20 range 0..99, default 45
// - outside air reading held within -60..80
// - field adjust key toggles mode and lamp
// - select steps settings, arrows change value
package cmd_interp_pkg;

	localparam int CLK_FREQ_HZ     = 40_000_000;
	localparam int BAUD_RATE       = 9600;
	localparam int BIT_CYCLES_DFLT = CLK_FREQ_HZ / BAUD_RATE;
	localparam int CNT_W           = 13;
	localparam int NUM_PARAMS      = 21;

	localparam logic [3:0] FRAME_LAST_BIT = 4'h9;
	localparam logic [3:0] STOP_BIT_IDX   = 4'h9;
	localparam logic [6:0] FIRST_RW_PAR   = 7'h05;
	localparam logic [6:0] LAST_PAR       = 7'h14;
	localparam logic [4:0] SEL_FIRST      = 5'h05;
	localparam logic [4:0] SEL_LAST_PAR   = 5'h14;
	localparam logic [4:0] SEL_PORT_MODE  = 5'h15;
	localparam logic [4:0] ADDR_PORT_MODE = 5'h15;
	localparam logic [2:0] MAX_VAL_DIGITS = 3'h4;
	localparam logic [9:0] MAG_LIMIT      = 10'h3e7;

	localparam logic [7:0] CHR_CR    = 8'h0d;
	localparam logic [7:0] CHR_QUERY = 8'h3f;
	localparam logic [7:0] CHR_SET   = 8'h40;
	localparam logic [7:0] CHR_EQ    = 8'h3d;
	localparam logic [7:0] CHR_MINUS = 8'h2d;
	localparam logic [7:0] CHR_ZERO  = 8'h30;
	localparam logic [7:0] CHR_NINE  = 8'h39;
	localparam logic [7:0] CHR_XON   = 8'h11;
	localparam logic [7:0] CHR_XOFF  = 8'h13;

	localparam logic [2:0] LOGIN_LEN = 3'h7;
	localparam logic [0:6][7:0] LOGIN_STR =
		{8'h50, 8'h3d, 8'h67, 8'h6f, 8'h62, 8'h6d, 8'h73};

	localparam logic signed [11:0] OAT_MIN = 12'hfc4;
	localparam logic signed [11:0] OAT_MAX = 12'h050;

	// entries 00..04 are live readings and never stored
	localparam logic [0:20][11:0] PAR_MIN = {
		12'h000, 12'h000, 12'h000, 12'h000, 12'h000,
		12'h020, 12'h000, 12'h028, 12'h028, 12'h000, 12'h028,
		12'h003, 12'h028, 12'h028, 12'h019, 12'h00a, 12'h000,
		12'h000, 12'hf38, 12'h005, 12'h000};
	localparam logic [0:20][11:0] PAR_MAX = {
		12'h000, 12'h000, 12'h000, 12'h000, 12'h000,
		12'h078, 12'h001, 12'h0dc, 12'h0dc, 12'h0c8, 12'h0dc,
		12'h01e, 12'h0dc, 12'h0dc, 12'h064, 12'h02d, 12'h3e7,
		12'h002, 12'h0c8, 12'h064, 12'h063};
	localparam logic [0:20][11:0] PAR_RST = {
		12'h000, 12'h000, 12'h000, 12'h000, 12'h000,
		12'h046, 12'h000, 12'h0a0, 12'h046, 12'h000, 12'h0a0,
		12'h00c, 12'h0dc, 12'h028, 12'h02d, 12'h012, 12'h00f,
		12'h001, 12'h00f, 12'h046, 12'h02d};

	localparam logic PORT_MODE_NORMAL = 1'b0;
	localparam logic PORT_MODE_NET    = 1'b1;
	localparam logic PORT_MODE_RST    = PORT_MODE_NET;

	typedef enum logic [6:0] {
		ST_LOGIN = 7'h01,
		ST_CMD   = 7'h02,
		ST_NUM   = 7'h04,
		ST_VAL   = 7'h08,
		ST_SKIP  = 7'h10,
		ST_SEND  = 7'h20,
		ST_SPARE = 7'h40
	} st_e;

	typedef struct packed {
		logic             rx_busy;
		logic [CNT_W-1:0] rx_cnt;
		logic [3:0]       rx_bit;
		logic [7:0]       rx_sh;
		logic             rx_vld;
		logic [7:0]       rx_byte;
		logic             tx_line;
		logic             tx_busy;
		logic [CNT_W-1:0] tx_cnt;
		logic [3:0]       tx_bit;
		logic [8:0]       tx_sh;
		logic             xoff;
		st_e              st;
		logic             logged;
		logic [2:0]       lidx;
		logic             cmd_write;
		logic [6:0]       num;
		logic [1:0]       ndig;
		logic             neg;
		logic [2:0]       vdig;
		logic [13:0]      acc;
		logic [13:0]      prev;
		logic [0:4][7:0]  rsp;
		logic [2:0]       rlen;
		logic [2:0]       ridx;
		logic [0:20][11:0] params;
		logic             port_mode;
		logic             fadj;
		logic [4:0]       sel;
		logic [11:0]      disp;
		logic [15:0]      rdata;
	} state_s;

endpackage : cmd_interp_pkg

/* File: dv/serial_terminal.sv */
// terminal model: serial sender and frame receiver beyond the port
`timescale 1ns/1ps
`default_nettype none

module serial_terminal #(
	parameter int BIT_CYCLES = 16
) (
	input  wire logic CORE_CLK_I, // shared clock, bit timing reference
	input  wire logic LINE_I,     // device transmit line
	output var  logic LINE_O      // line into the device
);
	logic [7:0] rx_q [$];

	// idle line stays high between frames
	initial LINE_O = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// fixed rate, 8N1, no flow control
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		@(posedge CORE_CLK_I);
		for (int i = 0; i < 10; i++) begin
			LINE_O <= fr[i];
			repeat (BIT_CYCLES) @(posedge CORE_CLK_I);
		end
	endtask : send_byte

	task automatic send_cmd(input string s);
		for (int i = 0; i < s.len(); i++)
			send_byte(s[i]);
		send_byte(8'h0d);
	endtask : send_cmd

	////////////////////////////////////////////////////////////////////////
	// lsb first; a frame with a low stop bit is dropped
	always begin : rx_proc
		logic [7:0] b;
		@(posedge CORE_CLK_I);
		if (LINE_I === 1'b0) begin
			repeat (BIT_CYCLES / 2) @(posedge CORE_CLK_I);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYCLES) @(posedge CORE_CLK_I);
				b[i] = LINE_I;
			end
			repeat (BIT_CYCLES) @(posedge CORE_CLK_I);
			if (LINE_I === 1'b1)
				rx_q.push_back(b);
		end
	end
endmodule : serial_terminal

`default_nettype wire

/* File: dv/tb_serial_cmd_interp.sv */
// self-checking bench for the serial command interpreter
`timescale 1ns/1ps
`default_nettype none

module tb_serial_cmd_interp;
	logic        clk;
	logic        rst;
	logic        rx;
	logic        tx;
	logic [11:0] hdr_t, oat_t, in_t, fire_t, tgt_t;
	logic        fadj_key, sel_key, up_key, down_key;
	logic        lamp, port_mode, session;
	logic [4:0]  sel;
	logic [11:0] sval;
	logic [4:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic        reg_wr, reg_rd;
	int          n_mismatch, check_count;

	logic [4:0]  radr [7] = '{5'h05, 5'h07, 5'h0c, 5'h11, 5'h14, 5'h15, 5'h19};
	logic [15:0] rexp [7] = '{16'h0046, 16'h00a0, 16'h00dc, 16'h0001,
		16'h002d, 16'h0001, 16'h0000};
	logic [15:0] lexp [5] = '{16'h00b4, 16'hffc4, 16'h0048, 16'h0032,
		16'h00a0};
	string       vcmd [3] = '{"?05", "?01", "?00"};
	string       vexp [3] = '{"70", "-60", "180"};
	string       wcmd [10] = '{"@05=650", "@05=1300", "@05=320", "@02=500",
		"@17=20", "@17=30", "@20=990", "@20=1000", "@12=400", "@07=2210"};
	logic [4:0]  wadr [10] = '{5'h05, 5'h05, 5'h05, 5'h02, 5'h11, 5'h11,
		5'h14, 5'h14, 5'h0c, 5'h07};
	logic [15:0] wexp [10] = '{16'h0041, 16'h0041, 16'h0020, 16'h0048,
		16'h0002, 16'h0002, 16'h0063, 16'h0063, 16'h0028, 16'h00a0};

	// short bit time keeps each frame at 160 cycles
	serial_cmd_interp #(.BIT_CYCLES(16)) i_serial_cmd_interp (
		.CORE_CLK_I(clk), .RESET_I(rst), .RX_I(rx), .TX_O(tx),
		.HDR_TEMP_I(hdr_t), .OAT_TEMP_I(oat_t), .INDOOR_TEMP_I(in_t),
		.FIRE_RATE_I(fire_t), .HDR_TARGET_I(tgt_t),
		.FIELD_ADJUST_KEY_KEY_I(fadj_key), .SELECT_KEY_I(sel_key),
		.UP_KEY_I(up_key), .DOWN_KEY_I(down_key),
		.FIELD_ADJUST_KEY_LAMP_O(lamp), .SETTING_SEL_O(sel), .SETTING_VAL_O(sval),
		.SERIAL_PORT_MODE_O(port_mode), .SESSION_OPEN_O(session),
		.REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr),
		.REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata));

	serial_terminal #(.BIT_CYCLES(16)) i_serial_terminal (
		.CORE_CLK_I(clk), .LINE_I(tx), .LINE_O(rx));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [15:0] got,
		input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : check

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report

	task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	// read data stand only in the cycle after the strobe
	task automatic reg_check(input logic [4:0] a, input logic [15:0] exp,
		input string nm);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		check(nm, reg_rdata, exp);
	endtask : reg_check

	// key order: field adjust, select, up, down
	task automatic press(input logic [3:0] k);
		@(posedge clk);
		{fadj_key, sel_key, up_key, down_key} <= k;
		@(posedge clk);
		{fadj_key, sel_key, up_key, down_key} <= 4'h0;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask : press

	task automatic expect_reply(input string s, input string nm);
		int n;
		n = 0;
		while (i_serial_terminal.rx_q.size() < s.len() + 1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		for (int i = 0; i < s.len(); i++)
			check(nm, {8'h00, i_serial_terminal.rx_q[i]}, {8'h00, s[i]});
		check(nm, {8'h00, i_serial_terminal.rx_q[s.len()]}, 16'h000d);
		i_serial_terminal.rx_q.delete();
	endtask : expect_reply

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// whole run needs about 30000 cycles
	initial begin : watchdog
		repeat (90000) @(posedge clk);
		n_mismatch++;
		final_report();
	end

	initial begin
		rst = 1'b1;
		{fadj_key, sel_key, up_key, down_key} = 4'h0;
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		hdr_t = 12'h0b4;
		oat_t = 12'hf9c;
		in_t = 12'h048;
		fire_t = 12'h032;
		tgt_t = 12'h0a0;
		n_mismatch = 0;
		check_count = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++)
			reg_check(radr[i], rexp[i], "reset value");
		for (int i = 0; i < 5; i++)
			reg_check(5'(i), lexp[i], "live value");
		@(posedge clk);
		oat_t <= 12'h05a;
		reg_check(5'h01, 16'h0050, "oat clamp");
		@(posedge clk);
		oat_t <= 12'hf9c;
		$display("test reset done");

		i_serial_terminal.send_cmd("P=gobms");
		i_serial_terminal.send_cmd("?05");
		repeat (400) @(posedge clk);
		@(negedge clk);
		check("net session", {15'h0000, session}, 16'h0000);
		check("net reply", 16'(i_serial_terminal.rx_q.size()), 16'h0000);
		$display("test network mode done");

		press(4'h8);
		check("lamp on", {15'h0000, lamp}, 16'h0001);
		check("first value", {4'h0, sval}, 16'h0046);
		press(4'h2);
		check("arrow up", {4'h0, sval}, 16'h0047);
		press(4'h1);
		check("arrow down", {4'h0, sval}, 16'h0046);
		repeat (16) press(4'h4);
		check("select walk", {11'h000, sel}, 16'h0015);
		press(4'h1);
		press(4'h8);
		check("lamp off", {15'h0000, lamp}, 16'h0000);
		check("port mode", {15'h0000, port_mode}, 16'h0000);
		press(4'h4);
		check("select idle", {11'h000, sel}, 16'h0015);
		reg_write(5'h15, 16'h0001);
		reg_check(5'h15, 16'h0001, "mode reg");
		reg_write(5'h15, 16'h0000);
		$display("test panel done");

		i_serial_terminal.send_cmd("P=GOBMS");
		@(negedge clk);
		check("bad login", {15'h0000, session}, 16'h0000);
		i_serial_terminal.send_cmd("P=gobms");
		@(negedge clk);
		check("good login", {15'h0000, session}, 16'h0001);
		$display("test login done");

		for (int i = 0; i < 3; i++) begin
			i_serial_terminal.send_cmd(vcmd[i]);
			expect_reply(vexp[i], vcmd[i]);
		end
		$display("test view done");

		for (int i = 0; i < 10; i++) begin
			i_serial_terminal.send_cmd(wcmd[i]);
			repeat (600) @(posedge clk);
			i_serial_terminal.rx_q.delete();
			reg_check(wadr[i], wexp[i], wcmd[i]);
		end
		$display("test write done");

		// reply held back while paused, released by resume
		i_serial_terminal.send_byte(8'h13);
		i_serial_terminal.send_cmd("?20");
		repeat (300) @(posedge clk);
		@(negedge clk);
		check("paused", 16'(i_serial_terminal.rx_q.size()), 16'h0000);
		i_serial_terminal.send_byte(8'h11);
		expect_reply("99", "resumed");
		$display("test flow control done");
		final_report();
	end
endmodule : tb_serial_cmd_interp

`default_nettype wire
